/* File: design/cgirq_pkg.sv */
/*
 * Package for the clock unit interrupt and core clock gate register slice.
 * Assumes a 32-bit APB slave; offsets are byte addresses.
 */
package cgirq_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [11:0] ADDR_FLAG_STATUS     = 12'h030;
    localparam logic [11:0] ADDR_FLAG_SET        = 12'h034;
    localparam logic [11:0] ADDR_IRQ_FLAG_CLEAR  = 12'h038;
    localparam logic [11:0] ADDR_IRQ_ENABLE_MASK = 12'h03c;
    localparam logic [11:0] ADDR_CORE_CLOCK_GATES = 12'h040;
    // ==========================================================
    // Field layout
    localparam int IRQ_W  = 6;
    localparam int GATE_W = 4;
    localparam int BIT_FAST_RC_OSC_READY     = 0;
    localparam int BIT_FAST_CRYSTAL_READY    = 1;
    localparam int BIT_SLOW_RC_OSC_READY     = 2;
    localparam int BIT_SLOW_CRYSTAL_READY    = 3;
    localparam int BIT_AUX_FAST_RC_OSC_READY = 4;
    localparam int BIT_CALIBRATION_DONE      = 5;
    localparam int BIT_AES_CLK_GATE          = 0;
    localparam int BIT_DMA_CLK_GATE          = 1;
    localparam int BIT_LOW_ENERGY_BUS_CLK_GATE     = 2;
    localparam int BIT_EXTERNAL_BUS_IFACE_CLK_GATE = 3;
    // ==========================================================
    // Reset values
    localparam logic [IRQ_W-1:0]  RST_FLAGS  = 6'h00;
    localparam logic [IRQ_W-1:0]  RST_ENABLE = 6'h00;
    localparam logic [GATE_W-1:0] RST_GATES  = 4'h0;
    localparam logic [31:0]       READ_ZERO  = 32'h0000_0000;
endpackage : cgirq_pkg

/* File: design/cgirq_clk_gate.sv */
/*
 * Latch-based glitch-free clock gate.
 * Assumes the enable comes from a register clocked by clk_in.
 */
`timescale 1ns/1ps
module cgirq_clk_gate (
    input  wire logic clk_in,
    input  wire logic enable,
    output logic      clk_out
);
    logic en_latched;

    // Latch open while clock low so the enable cannot chop a high phase
    always_latch begin
        if (!clk_in) begin
            en_latched <= enable;
        end
    end

    assign clk_out = clk_in & en_latched;
endmodule : cgirq_clk_gate

/* File: design/cgirq_regs.sv */
/*
 * Interrupt flag, enable and core clock gate registers on APB.
 * Assumes oscillator logic pulses the ready/done event inputs in clk domain.
 */
// Our own choice: register access over APB.
`timescale 1ns/1ps
module cgirq_regs
    import cgirq_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [IRQ_W-1:0]  osc_event,
    output logic                   irq,
    output logic      [IRQ_W-1:0]  irq_flags,
    output logic      [GATE_W-1:0] core_clock_gates,
    output logic                   external_bus_iface_clk,
    output logic                   low_energy_bus_clk,
    output logic                   dma_clk,
    output logic                   aes_clk
);
    // ==========================================================
    // APB decode
    logic              access;
    logic              wr;
    logic              rd;
    logic              mapped;
    logic [IRQ_W-1:0]  flags;
    logic [IRQ_W-1:0]  next_flags;
    logic [IRQ_W-1:0]  irq_enable_mask;
    logic [IRQ_W-1:0]  next_irq_enable_mask;
    logic [GATE_W-1:0] next_core_clock_gates;
    logic [IRQ_W-1:0]  set_vec;
    logic [IRQ_W-1:0]  clr_vec;
    logic [31:0]       next_prdata;
    logic              next_irq;
    logic              setup_rd;
    logic              clear_write;
    logic              set_write;
    logic              enable_write;
    logic              gate_write;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction : hit

    // Zero-wait slave; only the low byte carries fields
    assign access = psel & penable;
    assign wr     = access & pwrite;
    assign rd     = access & ~pwrite;
    assign mapped = hit(paddr, ADDR_FLAG_STATUS) | hit(paddr, ADDR_FLAG_SET)
                  | hit(paddr, ADDR_IRQ_FLAG_CLEAR) | hit(paddr, ADDR_IRQ_ENABLE_MASK)
                  | hit(paddr, ADDR_CORE_CLOCK_GATES);
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // Read data is registered at the end of the setup cycle, so the
    // access phase still answers with no wait state
    assign setup_rd     = psel & ~penable & ~pwrite;
    assign clear_write  = wr & pstrb[0] & hit(paddr, ADDR_IRQ_FLAG_CLEAR);
    assign set_write    = wr & pstrb[0] & hit(paddr, ADDR_FLAG_SET);
    assign enable_write = wr & pstrb[0] & hit(paddr, ADDR_IRQ_ENABLE_MASK);
    assign gate_write   = wr & pstrb[0] & hit(paddr, ADDR_CORE_CLOCK_GATES);

    // ==========================================================
    // Flags
    always_comb begin
        set_vec = osc_event;
        clr_vec = '0;
        if (wr && pstrb[0] && hit(paddr, ADDR_FLAG_SET)) begin
            set_vec = set_vec | pwdata[IRQ_W-1:0];
        end
        if (wr && pstrb[0] && hit(paddr, ADDR_IRQ_FLAG_CLEAR)) begin
            clr_vec = pwdata[IRQ_W-1:0];
        end
        // Set wins over clear so a same-cycle event is kept
        next_flags = (flags & ~clr_vec) | set_vec;
    end

    // ==========================================================
    // Enable mask and clock gates
    always_comb begin
        next_irq_enable_mask  = irq_enable_mask;
        next_core_clock_gates = core_clock_gates;
        if (wr && pstrb[0] && hit(paddr, ADDR_IRQ_ENABLE_MASK)) begin
            next_irq_enable_mask = pwdata[IRQ_W-1:0];
        end
        if (wr && pstrb[0] && hit(paddr, ADDR_CORE_CLOCK_GATES)) begin
            // Upper bits dropped; software keeps them zero
            next_core_clock_gates = pwdata[GATE_W-1:0];
        end
    end

    // ==========================================================
    // Read mux and interrupt
    always_comb begin
        next_prdata = READ_ZERO;
        if (setup_rd) begin
            if (hit(paddr, ADDR_FLAG_STATUS)) begin
                next_prdata[IRQ_W-1:0] = flags;
            end else if (hit(paddr, ADDR_IRQ_ENABLE_MASK)) begin
                next_prdata[IRQ_W-1:0] = irq_enable_mask;
            end else if (hit(paddr, ADDR_CORE_CLOCK_GATES)) begin
                next_prdata[GATE_W-1:0] = core_clock_gates;
            end
            // Flag-clear and flag-set read zero, no effect
        end
        next_irq = |(next_flags & next_irq_enable_mask);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flags            <= RST_FLAGS;
            irq_enable_mask  <= RST_ENABLE;
            core_clock_gates <= RST_GATES;
            irq              <= 1'b0;
            prdata           <= READ_ZERO;
        end else begin
            flags            <= next_flags;
            irq_enable_mask  <= next_irq_enable_mask;
            core_clock_gates <= next_core_clock_gates;
            irq              <= next_irq;
            prdata           <= next_prdata;
        end
    end

    assign irq_flags = flags;

    // ==========================================================
    // Clock gates
    cgirq_clk_gate u_gate_ext_bus (
        .clk_in  (clk),
        .enable  (core_clock_gates[BIT_EXTERNAL_BUS_IFACE_CLK_GATE]),
        .clk_out (external_bus_iface_clk)
    );
    cgirq_clk_gate u_gate_low_energy (
        .clk_in  (clk),
        .enable  (core_clock_gates[BIT_LOW_ENERGY_BUS_CLK_GATE]),
        .clk_out (low_energy_bus_clk)
    );
    cgirq_clk_gate u_gate_dma (
        .clk_in  (clk),
        .enable  (core_clock_gates[BIT_DMA_CLK_GATE]),
        .clk_out (dma_clk)
    );
    cgirq_clk_gate u_gate_aes (
        .clk_in  (clk),
        .enable  (core_clock_gates[BIT_AES_CLK_GATE]),
        .clk_out (aes_clk)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_clear_cal_flag: assert property (
        (wr && pstrb[0] && hit(paddr, ADDR_IRQ_FLAG_CLEAR) && pwdata[BIT_CALIBRATION_DONE]
         && !osc_event[BIT_CALIBRATION_DONE]) |=> !flags[BIT_CALIBRATION_DONE])
        else $error("calibration flag not cleared");
    chk_clear_zero_keeps: assert property (
        (wr && hit(paddr, ADDR_IRQ_FLAG_CLEAR) && !pwdata[BIT_AUX_FAST_RC_OSC_READY])
        |=> flags[BIT_AUX_FAST_RC_OSC_READY] == $past(flags[BIT_AUX_FAST_RC_OSC_READY])
            || $past(set_vec[BIT_AUX_FAST_RC_OSC_READY]))
        else $error("flag changed on zero clear");
    chk_event_sets: assert property (
        osc_event[BIT_SLOW_CRYSTAL_READY] |=> flags[BIT_SLOW_CRYSTAL_READY])
        else $error("event did not set flag");
    chk_set_reg_sets: assert property (
        (wr && pstrb[0] && hit(paddr, ADDR_FLAG_SET) && pwdata[BIT_SLOW_RC_OSC_READY])
        |=> flags[BIT_SLOW_RC_OSC_READY])
        else $error("flag-set write ignored");
    chk_irq_follows: assert property (
        irq == |(flags & irq_enable_mask))
        else $error("irq disagrees with flags and mask");
    chk_enable_write: assert property (
        (wr && pstrb[0] && hit(paddr, ADDR_IRQ_ENABLE_MASK))
        |=> irq_enable_mask[BIT_FAST_CRYSTAL_READY] == $past(pwdata[BIT_FAST_CRYSTAL_READY]))
        else $error("enable bit not written");
    chk_gate_write: assert property (
        (wr && pstrb[0] && hit(paddr, ADDR_CORE_CLOCK_GATES))
        |=> core_clock_gates == $past(pwdata[GATE_W-1:0]))
        else $error("gate register not written");
    chk_clear_read_zero: assert property (
        (rd && hit(paddr, ADDR_IRQ_FLAG_CLEAR)) |-> prdata == READ_ZERO ##1 $stable(flags)
            || $past(|set_vec))
        else $error("flag-clear read not zero");
    chk_gates_hold: assert property (
        !(wr && hit(paddr, ADDR_CORE_CLOCK_GATES)) |=> $stable(core_clock_gates))
        else $error("gate changed without write");

    // ==========================================================
    // Per-bit clear checks
    chk_clear_aux_flag: assert property (
        (clear_write && pwdata[BIT_AUX_FAST_RC_OSC_READY]
         && !osc_event[BIT_AUX_FAST_RC_OSC_READY]) |=> !flags[BIT_AUX_FAST_RC_OSC_READY])
        else $error("aux rc flag not cleared");
    chk_clear_slow_xtal: assert property (
        (clear_write && pwdata[BIT_SLOW_CRYSTAL_READY]
         && !osc_event[BIT_SLOW_CRYSTAL_READY]) |=> !flags[BIT_SLOW_CRYSTAL_READY])
        else $error("slow crystal flag not cleared");
    chk_clear_slow_rc: assert property (
        (clear_write && pwdata[BIT_SLOW_RC_OSC_READY]
         && !osc_event[BIT_SLOW_RC_OSC_READY]) |=> !flags[BIT_SLOW_RC_OSC_READY])
        else $error("slow rc flag not cleared");
    chk_clear_fast_xtal: assert property (
        (clear_write && pwdata[BIT_FAST_CRYSTAL_READY]
         && !osc_event[BIT_FAST_CRYSTAL_READY]) |=> !flags[BIT_FAST_CRYSTAL_READY])
        else $error("fast crystal flag not cleared");
    chk_clear_fast_rc: assert property (
        (clear_write && pwdata[BIT_FAST_RC_OSC_READY]
         && !osc_event[BIT_FAST_RC_OSC_READY]) |=> !flags[BIT_FAST_RC_OSC_READY])
        else $error("fast rc flag not cleared");
    // A pending event must survive a clear in the same cycle
    chk_set_beats_clear: assert property (
        (clear_write && pwdata[BIT_CALIBRATION_DONE]
         && osc_event[BIT_CALIBRATION_DONE]) |=> flags[BIT_CALIBRATION_DONE])
        else $error("event lost against clear");

    // ==========================================================
    // Per-bit enable checks
    chk_enable_cal: assert property (
        enable_write
        |=> irq_enable_mask[BIT_CALIBRATION_DONE] == $past(pwdata[BIT_CALIBRATION_DONE]))
        else $error("calibration enable not written");
    chk_enable_aux: assert property (
        enable_write |=> irq_enable_mask[BIT_AUX_FAST_RC_OSC_READY]
            == $past(pwdata[BIT_AUX_FAST_RC_OSC_READY]))
        else $error("aux rc enable not written");
    chk_enable_slow_xtal: assert property (
        enable_write |=> irq_enable_mask[BIT_SLOW_CRYSTAL_READY]
            == $past(pwdata[BIT_SLOW_CRYSTAL_READY]))
        else $error("slow crystal enable not written");
    chk_enable_slow_rc: assert property (
        enable_write |=> irq_enable_mask[BIT_SLOW_RC_OSC_READY]
            == $past(pwdata[BIT_SLOW_RC_OSC_READY]))
        else $error("slow rc enable not written");
    chk_enable_fast_rc: assert property (
        enable_write |=> irq_enable_mask[BIT_FAST_RC_OSC_READY]
            == $past(pwdata[BIT_FAST_RC_OSC_READY]))
        else $error("fast rc enable not written");
    chk_enable_hold: assert property (
        !enable_write |=> $stable(irq_enable_mask))
        else $error("enable mask changed without write");
    chk_irq_needs_enable: assert property (
        (irq_enable_mask == '0) |-> !irq)
        else $error("irq raised with all sources masked");

    // ==========================================================
    // Gate, set and event checks
    chk_gate_low_energy: assert property (
        gate_write |=> core_clock_gates[BIT_LOW_ENERGY_BUS_CLK_GATE]
            == $past(pwdata[BIT_LOW_ENERGY_BUS_CLK_GATE]))
        else $error("low energy gate not written");
    chk_gate_dma: assert property (
        gate_write |=> core_clock_gates[BIT_DMA_CLK_GATE]
            == $past(pwdata[BIT_DMA_CLK_GATE]))
        else $error("dma gate not written");
    chk_set_reg_all: assert property (
        set_write
        |=> (flags & $past(pwdata[IRQ_W-1:0])) == $past(pwdata[IRQ_W-1:0]))
        else $error("flag-set write missed a bit");
    chk_event_all: assert property (
        (|osc_event) |=> (flags & $past(osc_event)) == $past(osc_event))
        else $error("event missed a flag");
    chk_flags_no_stray: assert property (
        (set_vec == '0 && clr_vec == '0) |=> $stable(flags))
        else $error("flag changed with no cause");
    // Strobe-less writes must not touch the control registers
    chk_strobe_off: assert property (
        (access && pwrite && !pstrb[0])
        |=> $stable(irq_enable_mask) && $stable(core_clock_gates))
        else $error("write without strobe took effect");

    // ==========================================================
    // Read path checks
    chk_ready_high: assert property (
        access |-> pready)
        else $error("access phase not ready");
    chk_unmapped_err: assert property (
        (access && !mapped) |-> pslverr && prdata == READ_ZERO)
        else $error("unmapped access not refused");
    chk_reserved_zero: assert property (
        rd |-> prdata[31:IRQ_W] == '0)
        else $error("reserved read bits not zero");
    chk_write_no_data: assert property (
        (access && pwrite) |-> prdata == READ_ZERO)
        else $error("read data shown on a write");
    chk_idle_no_data: assert property (
        !psel |=> prdata == READ_ZERO)
        else $error("read data shown while idle");
    chk_read_flags: assert property (
        (rd && hit(paddr, ADDR_FLAG_STATUS))
        |-> prdata[IRQ_W-1:0] == $past(flags))
        else $error("flag read wrong");
    chk_read_enable: assert property (
        (rd && hit(paddr, ADDR_IRQ_ENABLE_MASK))
        |-> prdata[IRQ_W-1:0] == $past(irq_enable_mask))
        else $error("enable read wrong");
    chk_read_gates: assert property (
        (rd && hit(paddr, ADDR_CORE_CLOCK_GATES))
        |-> prdata[GATE_W-1:0] == $past(core_clock_gates))
        else $error("gate read wrong");

    cov_irq_raise: cover property (!irq ##1 irq);
    cov_set_clear_same: cover property (|(set_vec & clr_vec));
    cov_gate_on: cover property (core_clock_gates == 4'hf);
    cov_unmapped: cover property (pslverr);
    cov_clear_write: cover property (clear_write);
endmodule : cgirq_regs

/* File: testbench/tb.sv */
/*
 * Self-checking bench for the interrupt flag, enable and core clock gate registers.
 * Assumes cgirq_regs answers APB with no wait states and drives gated clocks from clk.
 */
`timescale 1ns/1ps
module tb
    import cgirq_pkg::*;
();
    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0000_0000;
    logic [3:0]        pstrb = 4'hf;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [IRQ_W-1:0]  osc_event = 6'h00;
    logic              irq;
    logic [IRQ_W-1:0]  irq_flags;
    logic [GATE_W-1:0] core_clock_gates;
    logic              ext_bus_clk, low_energy_clk, dma_clk, aes_clk;
    logic [31:0]       r, m;
    logic              e;
    int                fails = 0;
    int                samples_checked = 0;

    always #5 clk = ~clk;

    cgirq_regs cgirq_regs_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_event(osc_event), .irq(irq),
        .irq_flags(irq_flags), .core_clock_gates(core_clock_gates),
        .external_bus_iface_clk(ext_bus_clk), .low_energy_bus_clk(low_energy_clk),
        .dma_clk(dma_clk), .aes_clk(aes_clk));

    // ==========================================================
    // Checking and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Called right after a rising edge; returns one edge after the edge that takes the transfer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        y;
        apb(1'b1, a, d, x, y);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        logic        y;
        apb(1'b0, a, 32'h0000_0000, x, y);
        chk(x, exp);
        chk({31'h0, y}, 32'h0000_0000);
    endtask : rd_chk

    // Irq is registered, so two edges let it settle
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irq_chk

    // Gated clocks are sampled in the high phase of clk
    task automatic gate_chk(input logic [3:0] exp);
        @(posedge clk);
        #2;
        chk({28'h0, ext_bus_clk, low_energy_clk, dma_clk, aes_clk}, {28'h0, exp});
        chk({28'h0, core_clock_gates}, {28'h0, exp});
        @(posedge clk);
    endtask : gate_chk

    task automatic report_and_stop();
        $display("Checks: %0d mismatches: %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // Tests
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd_chk(ADDR_FLAG_STATUS, 32'h0000_0000);
        rd_chk(ADDR_IRQ_ENABLE_MASK, 32'h0000_0000);
        rd_chk(ADDR_CORE_CLOCK_GATES, 32'h0000_0000);
        gate_chk(4'h0);
        $display("Test reset values done");
        wr(ADDR_IRQ_ENABLE_MASK, 32'h0000_002a);
        rd_chk(ADDR_IRQ_ENABLE_MASK, 32'h0000_002a);
        wr(ADDR_IRQ_ENABLE_MASK, 32'h0000_0015);
        rd_chk(ADDR_IRQ_ENABLE_MASK, 32'h0000_0015);
        for (int g = 0; g < 4; g++) begin
            wr(ADDR_CORE_CLOCK_GATES, 32'h0000_0001 << g);
            gate_chk(4'h1 << g);
        end
        wr(ADDR_CORE_CLOCK_GATES, 32'h0000_000a);
        rd_chk(ADDR_CORE_CLOCK_GATES, 32'h0000_000a);
        wr(ADDR_IRQ_ENABLE_MASK, 32'h0000_0000);
        $display("Test read-write fields done");
        for (int i = 0; i < IRQ_W; i++) begin
            m = 32'h0000_0001 << i;
            osc_event <= m[IRQ_W-1:0];
            @(posedge clk);
            osc_event <= 6'h00;
            rd_chk(ADDR_FLAG_STATUS, m);
            wr(ADDR_IRQ_FLAG_CLEAR, 32'h0000_003f ^ m);
            rd_chk(ADDR_IRQ_FLAG_CLEAR, 32'h0000_0000);
            rd_chk(ADDR_FLAG_STATUS, m);
            irq_chk(1'b0);
            wr(ADDR_IRQ_ENABLE_MASK, m);
            irq_chk(1'b1);
            wr(ADDR_IRQ_FLAG_CLEAR, m);
            rd_chk(ADDR_FLAG_STATUS, 32'h0000_0000);
            irq_chk(1'b0);
            wr(ADDR_FLAG_SET, m);
            chk({26'h0, irq_flags}, m);
            irq_chk(1'b1);
            wr(ADDR_IRQ_FLAG_CLEAR, m);
            wr(ADDR_IRQ_ENABLE_MASK, 32'h0000_0000);
        end
        $display("Test flags and interrupt done");
        apb(1'b0, 12'h044, 32'h0000_0000, r, e);
        chk(r, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        pstrb <= 4'h0;
        wr(ADDR_IRQ_ENABLE_MASK, 32'h0000_003f);
        pstrb <= 4'hf;
        rd_chk(ADDR_IRQ_ENABLE_MASK, 32'h0000_0000);
        wr(ADDR_CORE_CLOCK_GATES, 32'h0000_000f);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd_chk(ADDR_CORE_CLOCK_GATES, 32'h0000_0000);
        $display("Test refusals and mid-run reset done");
        report_and_stop();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        report_and_stop();
    end
endmodule : tb
